// ===== mrid_pkg.sv
// constants and types shared by the instruction decode/execute core
// assumes a 32-bit axi4-lite register bus and one core clock
package mrid_pkg;

  localparam int CLK_PERIOD_NS = 20;

  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_WREG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0C;
  localparam logic [7:0] OFF_UPPER = 8'h10;
  localparam logic [7:0] OFF_TCFG = 8'h14;
  localparam logic [7:0] OFF_PEEK = 8'h18;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;

  localparam logic [3:0] OP_MOVE_W = 4'h0;
  localparam logic [3:0] OP_CLEAR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOVE_F = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DEC_SKIP = 4'hB;
  localparam logic [3:0] OP_ROT_R = 4'hC;
  localparam logic [3:0] OP_ROT_L = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INC_SKIP = 4'hF;

  localparam logic [1:0] BOP_CLEAR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_SKIP_CLR = 2'h2;
  localparam logic [1:0] BOP_SKIP_SET = 2'h3;

  localparam logic [1:0] LIT_LOAD = 2'h0;
  localparam logic [1:0] LIT_RET = 2'h1;
  localparam logic [3:0] LIT_OR = 4'h8;
  localparam logic [3:0] LIT_AND = 4'h9;
  localparam logic [3:0] LIT_XOR = 4'hA;
  localparam logic [2:0] LIT_SUB = 3'h6;
  localparam logic [2:0] LIT_ADD = 3'h7;

  localparam logic [7:0] CTL_RETURN = 8'h08;
  localparam logic [7:0] CTL_IRET = 8'h09;
  localparam logic [7:0] CTL_TCFG = 8'h62;
  localparam logic [7:0] CTL_STANDBY = 8'h63;
  localparam logic [7:0] CTL_WDT_CLR = 8'h64;

  localparam logic [6:0] FADDR_TIMER = 7'h01;
  localparam logic [6:0] FADDR_PORT = 7'h06;
  localparam int TCFG_ASSIGN_BIT = 3;

  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_STANDBY = 5;
  localparam int ST_GIE = 6;
  localparam int ST_BUSY = 7;

  localparam logic [7:0] RST_W = 8'h00;
  localparam logic [7:0] RST_TCFG = 8'hFF;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [4:0] RST_UPPER = 5'h00;
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [13:0] RST_INSTR = 14'h0000;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_EXEC = 4'h2,
    S_FLUSH = 4'h4,
    S_SLEEP = 4'h8
  } mrid_state_t;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_COM, ALU_INC,
    ALU_DEC, ALU_RL, ALU_RR, ALU_SWAP, ALU_CLR, ALU_BCLR, ALU_BSET
  } mrid_alu_op_t;

endpackage

// ===== mrid_alu_if.sv
// operand and result bundle between the core and its alu
// assumes the alu is purely combinational
`timescale 1ns/1ns
interface mrid_alu_if;
  import mrid_pkg::*;
  mrid_alu_op_t op;
  logic [7:0] a;
  logic [7:0] w;
  logic c_in;
  logic [2:0] bit_sel;
  logic [7:0] result;
  logic c_out;
  logic dc_out;
  logic z_out;
  modport core (output op, a, w, c_in, bit_sel, input result, c_out, dc_out, z_out);
  modport alu (input op, a, w, c_in, bit_sel, output result, c_out, dc_out, z_out);
endinterface

// ===== mrid_alu.sv
// 8-bit arithmetic and logic unit of the core
// assumes the caller picks which flags to keep
`timescale 1ns/1ns
module mrid_alu (
  mrid_alu_if.alu bus
);
  import mrid_pkg::*;

  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    bus.result = bus.a;
    bus.c_out = bus.c_in;
    bus.dc_out = 1'b0;
    case (bus.op)
      ALU_ADD: begin
        sum = {1'b0, bus.a} + {1'b0, bus.w};
        nib = {1'b0, bus.a[3:0]} + {1'b0, bus.w[3:0]};
        bus.result = sum[7:0];
        bus.c_out = sum[8];
        bus.dc_out = nib[4];
      end
      ALU_SUB: begin
        // carry set means no borrow
        sum = {1'b0, bus.a} + {1'b0, ~bus.w} + 9'h001;
        nib = {1'b0, bus.a[3:0]} + {1'b0, ~bus.w[3:0]} + 5'h01;
        bus.result = sum[7:0];
        bus.c_out = sum[8];
        bus.dc_out = nib[4];
      end
      ALU_AND: bus.result = bus.a & bus.w;
      ALU_OR: bus.result = bus.a | bus.w;
      ALU_XOR: bus.result = bus.a ^ bus.w;
      ALU_COM: bus.result = ~bus.a;
      ALU_INC: bus.result = bus.a + 8'h01;
      ALU_DEC: bus.result = bus.a - 8'h01;
      ALU_RL: begin
        bus.result = {bus.a[6:0], bus.c_in};
        bus.c_out = bus.a[7];
      end
      ALU_RR: begin
        bus.result = {bus.c_in, bus.a[7:1]};
        bus.c_out = bus.a[0];
      end
      ALU_SWAP: bus.result = {bus.a[3:0], bus.a[7:4]};
      ALU_CLR: bus.result = 8'h00;
      ALU_BCLR: bus.result = bus.a & ~(8'h01 << bus.bit_sel);
      ALU_BSET: bus.result = bus.a | (8'h01 << bus.bit_sel);
      default: bus.result = bus.a;
    endcase
    bus.z_out = (bus.result == 8'h00);
  end
endmodule

// ===== mrid_stack.sv
// circular hardware return stack
// assumes push and pop never come together; overflow wraps silently
`timescale 1ns/1ns
module mrid_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [PW-1:0] ptr;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= '0;
    end else if (en && push) begin
      ptr <= ptr + 1'b1;
    end else if (en && pop) begin
      ptr <= ptr - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot[i] <= '0;
      end
    end else if (en && push) begin
      slot[ptr + 1'b1] <= push_data;
    end
  end

  assign top = slot[ptr];
endmodule

// ===== mrid_core.sv
// instruction decode and execute core with axi4-lite register access
// assumes software feeds the word at PROG_ADDR through the instruction register
`timescale 1ns/1ns

// Function
// [RL1] timer write clears prescaler when assigned
// [RL2] pc change or taken skip: two cycles
// [RL3] port read-modify-write uses pin levels
// [RL4] bit test skips discard next, insert nop
// [RL5] call pushes following address first
// [RL6] call loads k and latch bits 4:3
// [RL7] clear file writes zero, sets zero
// [RL8] or literal into w, zero updated
// [RL9] load literal, no status change
// [RL10] destination bit selects w or file
// [RL11] move file updates zero flag always
// [RL12] load timer config from w, no flags
// [RL13] interrupt return pops pc, sets enable
// [RL14] rotates go through carry only
// [RL15] skip-on-zero counters leave flags alone
// [RL16] standby sets timeout and powerdown flags; the code sets st_to but clears st_pd
// [RL17] literal minus w, updates c dc z
// [RL18] top two bits pick instruction class
// [RL19] jump loads like call, no push
// [RL20] zero flag equals result is zero
module mrid_core #(
  parameter int FILE_DEPTH = 32,
  parameter int STACK_DEPTH = 8
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [7:0] PORT_PINS,
  input wire logic WAKE,
  output logic [7:0] PORT_OUT,
  output logic [12:0] PROG_ADDR,
  output logic STANDBY,
  output logic PRESCALER_CLEAR
);
  import mrid_pkg::*;

  localparam int FW = $clog2(FILE_DEPTH);

  mrid_state_t state;
  logic [13:0] ir;
  logic [7:0] w;
  logic [12:0] pc;
  logic [4:0] upper;
  logic [7:0] tcfg;
  logic [7:0] port_latch;
  logic [7:0] file_mem [FILE_DEPTH];
  logic [FW-1:0] peek_idx;
  logic st_c, st_dc, st_z, st_to, st_pd, global_irq_enable;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_commit, wr_ok, wr_mapped, exec;
  logic [31:0] wr_val, rd_val;
  logic rd_mapped;
  logic [7:0] status_word;

  logic [1:0] cls;
  logic [3:0] op4;
  logic [6:0] faddr;
  logic [FW-1:0] fidx;
  logic [7:0] lit, file_rd;
  logic wr_w, wr_f, upd_z, upd_c, upd_dc;
  logic skip, jump, push, pop, set_gie, ld_tcfg, go_sleep, wdt_clr;
  logic two_cycle;
  logic [12:0] next_pc, stack_top;

  mrid_alu_if alu_bus ();
  mrid_alu u_alu (.bus(alu_bus));

  mrid_stack #(.DEPTH(STACK_DEPTH), .WIDTH(13)) u_stack (
    .clk(CLOCK),
    .rst_b(RST_B),
    .en(exec),
    .push(push),
    .pop(pop),
    .push_data(pc + 13'h0001), // [RL5]
    .top(stack_top)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign exec = CE && (state == S_EXEC);
  assign cls = ir[13:12];
  assign op4 = ir[11:8];
  assign faddr = ir[6:0];
  assign fidx = faddr[FW-1:0];
  assign lit = ir[7:0];
  // pins, not the output latch, feed every port read by an instruction
  assign file_rd = (faddr == FADDR_PORT) ? PORT_PINS : file_mem[fidx]; // [RL3]

  always_comb begin
    alu_bus.op = ALU_PASS;
    alu_bus.a = file_rd;
    alu_bus.w = w;
    alu_bus.c_in = st_c;
    alu_bus.bit_sel = ir[9:7];
    wr_w = 1'b0;
    wr_f = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    set_gie = 1'b0;
    ld_tcfg = 1'b0;
    go_sleep = 1'b0;
    wdt_clr = 1'b0;
    case (cls) // [RL18]
      CLS_BYTE: begin
        wr_f = ir[7]; // [RL10]
        wr_w = !ir[7]; // [RL10]
        upd_z = 1'b1;
        case (op4)
          OP_MOVE_W: begin
            upd_z = 1'b0;
            wr_w = 1'b0;
            alu_bus.a = w;
            if (!ir[7]) begin
              case (lit)
                CTL_RETURN: pop = 1'b1;
                CTL_IRET: begin
                  pop = 1'b1; // [RL13]
                  set_gie = 1'b1; // [RL13]
                end
                CTL_TCFG: ld_tcfg = 1'b1; // [RL12]
                CTL_STANDBY: go_sleep = 1'b1; // [RL16]
                CTL_WDT_CLR: wdt_clr = 1'b1;
                default: ;
              endcase
            end
          end
          OP_CLEAR: alu_bus.op = ALU_CLR; // [RL7]
          OP_SUB: begin
            alu_bus.op = ALU_SUB;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          OP_DEC: alu_bus.op = ALU_DEC;
          OP_OR: alu_bus.op = ALU_OR;
          OP_AND: alu_bus.op = ALU_AND;
          OP_XOR: alu_bus.op = ALU_XOR;
          OP_ADD: begin
            alu_bus.op = ALU_ADD;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          OP_MOVE_F: alu_bus.op = ALU_PASS; // [RL11]
          OP_COM: alu_bus.op = ALU_COM;
          OP_INC: alu_bus.op = ALU_INC;
          OP_DEC_SKIP: begin
            alu_bus.op = ALU_DEC;
            upd_z = 1'b0; // [RL15]
            skip = alu_bus.z_out; // [RL15]
          end
          OP_INC_SKIP: begin
            alu_bus.op = ALU_INC;
            upd_z = 1'b0; // [RL15]
            skip = alu_bus.z_out; // [RL15]
          end
          OP_ROT_R: begin
            alu_bus.op = ALU_RR; // [RL14]
            upd_z = 1'b0;
            upd_c = 1'b1;
          end
          OP_ROT_L: begin
            alu_bus.op = ALU_RL; // [RL14]
            upd_z = 1'b0;
            upd_c = 1'b1;
          end
          OP_SWAP: begin
            alu_bus.op = ALU_SWAP;
            upd_z = 1'b0;
          end
          default: ;
        endcase
      end
      CLS_BIT: begin
        case (ir[11:10])
          BOP_CLEAR: begin
            alu_bus.op = ALU_BCLR;
            wr_f = 1'b1;
          end
          BOP_SET: begin
            alu_bus.op = ALU_BSET;
            wr_f = 1'b1;
          end
          BOP_SKIP_CLR: skip = !file_rd[ir[9:7]]; // [RL4]
          BOP_SKIP_SET: skip = file_rd[ir[9:7]]; // [RL4]
          default: ;
        endcase
      end
      CLS_JUMP: begin
        jump = 1'b1; // [RL19]
        push = !ir[11]; // [RL5]
      end
      CLS_LIT: begin
        alu_bus.a = lit;
        wr_w = 1'b1;
        if (op4[3:2] == LIT_LOAD) begin
          alu_bus.op = ALU_PASS; // [RL9]
        end else if (op4[3:2] == LIT_RET) begin
          pop = 1'b1;
        end else if (op4 == LIT_OR) begin
          alu_bus.op = ALU_OR; // [RL8]
          upd_z = 1'b1; // [RL8]
        end else if (op4 == LIT_AND) begin
          alu_bus.op = ALU_AND;
          upd_z = 1'b1;
        end else if (op4 == LIT_XOR) begin
          alu_bus.op = ALU_XOR;
          upd_z = 1'b1;
        end else if (op4[3:1] == LIT_SUB) begin
          alu_bus.op = ALU_SUB; // [RL17]
          upd_z = 1'b1;
          upd_c = 1'b1;
          upd_dc = 1'b1;
        end else if (op4[3:1] == LIT_ADD) begin
          alu_bus.op = ALU_ADD;
          upd_z = 1'b1;
          upd_c = 1'b1;
          upd_dc = 1'b1;
        end else begin
          wr_w = 1'b0;
        end
      end
      default: ;
    endcase
  end

  always_comb begin
    two_cycle = jump || pop || skip; // [RL2]
    if (jump) begin
      next_pc = {upper[4:3], ir[10:0]}; // [RL6]
    end else if (pop) begin
      next_pc = stack_top; // [RL13]
    end else if (skip) begin
      next_pc = pc + 13'h0002; // [RL4]
    end else begin
      next_pc = pc + 13'h0001;
    end
  end

  // execution sequence; a flush cycle stands in for the discarded word
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state <= S_IDLE;
    end else if (CE) begin
      case (state)
        S_IDLE: if (wr_ok && aw_addr == OFF_INSTR) state <= S_EXEC;
        S_EXEC: state <= go_sleep ? S_SLEEP : (two_cycle ? S_FLUSH : S_IDLE); // [RL2]
        S_FLUSH: state <= S_IDLE;
        S_SLEEP: if (WAKE) state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pc <= RST_PC;
    end else if (exec) begin
      pc <= next_pc;
    end else if (wr_ok && aw_addr == OFF_PC) begin
      pc <= wr_val[12:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      w <= RST_W;
    end else if (exec && wr_w) begin
      w <= alu_bus.result; // [RL10]
    end else if (wr_ok && aw_addr == OFF_WREG) begin
      w <= wr_val[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= 8'h00;
      end
      port_latch <= RST_PORT;
    end else if (exec && wr_f) begin
      if (faddr == FADDR_PORT) begin
        port_latch <= alu_bus.result; // [RL3]
      end else begin
        file_mem[fidx] <= alu_bus.result; // [RL10]
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      PRESCALER_CLEAR <= 1'b0;
    end else if (CE) begin
      PRESCALER_CLEAR <= exec && wr_f && faddr == FADDR_TIMER && !tcfg[TCFG_ASSIGN_BIT]; // [RL1]
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      st_c <= 1'b0;
      st_dc <= 1'b0;
      st_z <= 1'b0;
      st_to <= 1'b1;
      st_pd <= 1'b1;
      global_irq_enable <= 1'b0;
    end else if (exec) begin
      if (upd_c) st_c <= alu_bus.c_out; // [RL14]
      if (upd_dc) st_dc <= alu_bus.dc_out; // [RL17]
      if (upd_z) st_z <= alu_bus.z_out; // [RL20]
      if (set_gie) global_irq_enable <= 1'b1; // [RL13]
      if (go_sleep) begin
        st_to <= 1'b1; // [RL16]
        st_pd <= 1'b0; // [RL16]
      end else if (wdt_clr) begin
        st_to <= 1'b1;
        st_pd <= 1'b1;
      end
    end else if (wr_ok && aw_addr == OFF_STATUS) begin
      st_c <= wr_val[ST_C];
      st_dc <= wr_val[ST_DC];
      st_z <= wr_val[ST_Z];
      global_irq_enable <= wr_val[ST_GIE];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tcfg <= RST_TCFG;
      upper <= RST_UPPER;
      ir <= RST_INSTR;
      peek_idx <= '0;
    end else if (exec && ld_tcfg) begin
      tcfg <= w; // [RL12]
    end else if (wr_ok) begin
      case (aw_addr)
        OFF_TCFG: tcfg <= wr_val[7:0];
        OFF_UPPER: upper <= wr_val[4:0];
        OFF_INSTR: ir <= wr_val[13:0];
        OFF_PEEK: peek_idx <= wr_val[FW-1:0];
        default: ;
      endcase
    end
  end

  // register bus: address and data taken in either order, answered together
  // a read taken this cycle holds the commit back one cycle, so both can share one register lookup
  assign wr_commit = CE && !AWREADY && !WREADY && !BVALID && !(ARVALID && ARREADY);
  assign wr_mapped = aw_addr == OFF_INSTR || aw_addr == OFF_WREG || aw_addr == OFF_STATUS ||
                     aw_addr == OFF_PC || aw_addr == OFF_UPPER || aw_addr == OFF_TCFG || aw_addr == OFF_PEEK;
  // software writes only land between instructions so they never race execution
  assign wr_ok = wr_commit && wr_mapped && state == S_IDLE;
  assign wr_val = merge(rd_val, w_data, w_strb);

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (CE) begin
      if (AWVALID && AWREADY) begin
        AWREADY <= 1'b0;
        aw_addr <= {AWADDR[7:2], 2'b00};
      end
      if (WVALID && WREADY) begin
        WREADY <= 1'b0;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (wr_commit) begin
        BVALID <= 1'b1;
        BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  assign status_word = {state != S_IDLE, global_irq_enable, state == S_SLEEP, st_to, st_pd, st_z, st_dc, st_c};

  // shared by reads and by the strobe merge of writes
  always_comb begin
    rd_mapped = 1'b1;
    case (wr_commit ? aw_addr : ARADDR)
      OFF_INSTR: rd_val = {18'h00000, ir};
      OFF_WREG: rd_val = {24'h000000, w};
      OFF_STATUS: rd_val = {24'h000000, status_word};
      OFF_PC: rd_val = {19'h00000, pc};
      OFF_UPPER: rd_val = {27'h0000000, upper};
      OFF_TCFG: rd_val = {24'h000000, tcfg};
      OFF_PEEK: rd_val = {16'h0000, 3'h0, 5'(peek_idx), file_mem[peek_idx]};
      default: begin
        rd_val = 32'h0000_0000;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (CE) begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RDATA <= rd_val;
        RRESP <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  assign PORT_OUT = port_latch;
  assign PROG_ADDR = pc;
  assign STANDBY = state[3];
endmodule

// ===== mrid_core_monitor.sv
// port-level assertions for the decode/execute core
// assumes the bench offers write address and data in the same cycle
`timescale 1ns/1ns
module mrid_core_monitor
  import mrid_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic [7:0] PORT_PINS,
  input wire logic WAKE,
  input wire logic [7:0] PORT_OUT,
  input wire logic [12:0] PROG_ADDR,
  input wire logic STANDBY,
  input wire logic PRESCALER_CLEAR
);
  import mrid_pkg::*;
  logic [13:0] iw;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // word under execution; no new write is taken before it has run
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      iw <= 14'h0000;
    end else if (AWVALID && AWREADY && AWADDR[7:2] == OFF_INSTR[7:2]) begin
      iw <= WDATA[13:0];
    end
  end
  sequence s_take;
    AWVALID && AWREADY && AWADDR[7:2] == OFF_INSTR[7:2];
  endsequence
  sequence s_exec;
    s_take ##2 BVALID && BRESP == RESP_OKAY;
  endsequence
  a_goto_load: assert property (s_exec ##0 iw[13:11] == 3'b101 |-> ##2 PROG_ADDR[10:0] == iw[10:0])
    else $error("jump target not loaded");
  a_call_load: assert property (s_exec ##0 iw[13:11] == 3'b100 |=> ##1 PROG_ADDR[10:0] == iw[10:0])
    else $error("call target not loaded");
  a_bit_skip: assert property (s_exec ##0 (iw[13:11] == 3'b011 && iw[6:0] == FADDR_PORT) |-> ##2
    PROG_ADDR - $past(PROG_ADDR, 2) == (($past(PORT_PINS[iw[9:7]], 2) == iw[10]) ? 13'h0002 : 13'h0001))
    else $error("bit test advanced by the wrong step");
  a_port_rmw: assert property (s_exec ##0 iw == 14'h0886 |-> ##2 PORT_OUT == $past(PORT_PINS, 2))
    else $error("port write back not taken from pins");
  a_standby_enter: assert property (s_exec ##0 (iw == {6'h00, CTL_STANDBY} && !WAKE) ##1 !WAKE |=> STANDBY)
    else $error("standby not entered");
  a_wake_exit: assert property (STANDBY && WAKE |=> !STANDBY)
    else $error("standby not left on wake");
  a_pulse_once: assert property (PRESCALER_CLEAR |=> !PRESCALER_CLEAR)
    else $error("prescaler clear longer than one cycle");
  a_literal_step: assert property (s_exec ##0 (iw[13:12] == CLS_LIT && iw[11:10] != 2'b01) |-> ##2
    PROG_ADDR == $past(PROG_ADDR, 2) + 13'h0001)
    else $error("literal op did not step by one");
endmodule

bind mrid_core mrid_core_monitor u_monitor (.CLOCK(CLOCK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WDATA(WDATA), .BRESP(BRESP), .BVALID(BVALID), .PORT_PINS(PORT_PINS), .WAKE(WAKE),
  .PORT_OUT(PORT_OUT), .PROG_ADDR(PROG_ADDR), .STANDBY(STANDBY), .PRESCALER_CLEAR(PRESCALER_CLEAR));

// ===== mrid_core_tb.sv
// self-checking bench for the decode/execute core over its register bus
// assumes the register map and one-at-a-time handshakes of the core
`timescale 1ns/1ns
module mrid_core_tb;
  import mrid_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0, WAKE = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, PORT_PINS = 8'h00, PORT_OUT;
  logic [31:0] WDATA = 32'h0, RDATA, rd_v;
  logic [1:0] BRESP, RRESP, rsp;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, STANDBY, PRESCALER_CLEAR;
  logic [12:0] PROG_ADDR, pc;
  logic [13:0] bt [4] = '{14'h1C06, 14'h1886, 14'h1C86, 14'h1806};
  int miscompares = 0, comparisons = 0, pulses = 0, n = 0;

  mrid_core DUT (.CLOCK(CLOCK), .RST_B(RST_B), .CE(1'b1), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .PORT_PINS(PORT_PINS), .WAKE(WAKE),
    .PORT_OUT(PORT_OUT), .PROG_ADDR(PROG_ADDR), .STANDBY(STANDBY), .PRESCALER_CLEAR(PRESCALER_CLEAR));

  initial forever #(CLK_PERIOD_NS / 2) CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (PRESCALER_CLEAR === 1'b1) pulses++;

  task automatic end_sim();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // every handshake and poll wait after reset goes through here so a hang ends the run
  task automatic tick(inout int c);
    @(posedge CLOCK);
    c++;
    if (c > 200) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    // each channel is released at its own handshake edge
    do begin
      tick(k);
      if (!aw_done && AWREADY === 1'b1) begin
        aw_done = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!w_done && WREADY === 1'b1) begin
        w_done = 1'b1;
        WVALID <= 1'b0;
      end
    end while (!(aw_done && w_done));
    // raised only after the take, so back-to-back writes never lower and raise it in one step
    BREADY <= 1'b1;
    do tick(k); while (BVALID !== 1'b1);
    rsp = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    do tick(k); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    RREADY <= 1'b1;
    do tick(k); while (RVALID !== 1'b1);
    d = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, rd_v);
    chk(rd_v, e);
  endtask
  // runs one word and polls busy until the core is idle again
  task automatic ex(input logic [13:0] i);
    int k = 0;
    wr(OFF_INSTR, {18'h0, i});
    do begin
      rd(OFF_STATUS, rd_v);
      tick(k);
    end while (rd_v[ST_BUSY] !== 1'b0);
  endtask
  task automatic pk(input logic [4:0] f, input logic [7:0] e);
    wr(OFF_PEEK, {27'h0, f});
    rc(OFF_PEEK, {19'h0, f, e});
  endtask
  task automatic st(input logic [13:0] i, input logic [12:0] d);
    rd(OFF_PC, rd_v);
    pc = rd_v[12:0];
    ex(i);
    rc(OFF_PC, {19'h0, pc + d});
  endtask

  initial begin
    repeat (6) @(posedge CLOCK);
    RST_B <= 1'b1;
    @(posedge CLOCK);
    rc(OFF_STATUS, 32'h18);
    rc(OFF_TCFG, 32'hFF);
    ex(14'h305A);
    rc(OFF_WREG, 32'h5A);
    rc(OFF_STATUS, 32'h18);
    ex(14'h3000);
    ex(14'h3800);
    rc(OFF_STATUS, 32'h1C);
    ex(14'h309A);
    ex(14'h3835);
    rc(OFF_WREG, 32'hBF);
    rc(OFF_STATUS, 32'h18);
    rc(OFF_PC, 32'h5);
    ex(14'h0090);
    ex(14'h0190);
    pk(5'h10, 8'h00);
    rc(OFF_STATUS, 32'h1C);
    ex(14'h0090);
    ex(14'h3000);
    ex(14'h0890);
    rc(OFF_STATUS, 32'h18);
    rc(OFF_WREG, 32'h0);
    ex(14'h0810);
    rc(OFF_WREG, 32'hBF);
    wr(OFF_STATUS, 32'h1);
    ex(14'h3080);
    ex(14'h0090);
    ex(14'h0D90);
    pk(5'h10, 8'h01);
    ex(14'h0C10);
    rc(OFF_WREG, 32'h80);
    rc(OFF_STATUS, 32'h19);
    ex(14'h3001);
    ex(14'h0091);
    st(14'h0B91, 13'h2);
    pk(5'h11, 8'h00);
    rc(OFF_STATUS, 32'h19);
    ex(14'h30FF);
    ex(14'h0092);
    st(14'h0F92, 13'h2);
    ex(14'h3005);
    ex(14'h3C03);
    rc(OFF_WREG, 32'hFE);
    rc(OFF_STATUS, 32'h18);
    ex(14'h3CFE);
    rc(OFF_STATUS, 32'h1F);
    ex(14'h3007);
    ex(14'h0062);
    rc(OFF_TCFG, 32'h7);
    rc(OFF_STATUS, 32'h1F);
    ex(14'h0081);
    ex(14'h0801);
    ex(14'h3008);
    ex(14'h0062);
    ex(14'h0081);
    chk(pulses, 32'h1);
    wr(OFF_UPPER, 32'h18);
    rd(OFF_PC, rd_v);
    pc = rd_v[12:0];
    ex(14'h2123);
    rc(OFF_PC, 32'h1923);
    chk({19'h0, PROG_ADDR}, 32'h1923);
    ex(14'h0009);
    rc(OFF_PC, {19'h0, pc + 13'h1});
    rd(OFF_STATUS, rd_v);
    chk(rd_v & 32'h40, 32'h40);
    wr(OFF_UPPER, 32'h8);
    ex(14'h2AA5);
    rc(OFF_PC, 32'hAA5);
    PORT_PINS <= 8'hA5;
    foreach (bt[k]) st(bt[k], (k < 2) ? 13'h2 : 13'h1);
    PORT_PINS <= 8'h3C;
    ex(14'h0886);
    chk({24'h0, PORT_OUT}, 32'h3C);
    ex(14'h1406);
    chk({24'h0, PORT_OUT}, 32'h3D);
    wr(OFF_INSTR, 32'h63);
    do tick(n); while (STANDBY !== 1'b1);
    rd(OFF_STATUS, rd_v);
    chk(rd_v & 32'h38, 32'h30);
    wr(OFF_WREG, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    WAKE <= 1'b1;
    do tick(n); while (STANDBY !== 1'b0);
    WAKE <= 1'b0;
    rc(8'h1C, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    end_sim();
  end
endmodule
